/* File: hdl/rtsl_port_stamp.sv */
`include "rtsl_regs.svh"

module rtsl_port_stamp (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // frame events for this port
  input  wire logic        sof,
  input  wire logic [31:0] local_time,
  input  wire logic        commit,
  input  wire logic        arm,
  input  wire logic        arm_mode,
  // visible stamp
  output logic [31:0]      stamp
);

  rtsl_pkg::rtsl_port_st_t s_q;
  rtsl_pkg::rtsl_port_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (arm_mode) begin
      // armed port stamps its next frame once, then disarms itself
      if (sof && s_q.armed) begin
        s_d.stamp = local_time;
        s_d.armed = 1'b0;
      end
      // a fresh arm beats a same-cycle disarm
      if (arm) begin
        s_d.armed = 1'b1;
      end
    end else begin
      if (sof) begin
        s_d.pend = local_time;
      end
      // stamp becomes visible only at frame end, never mid-frame
      if (commit) begin
        s_d.stamp = s_q.pend;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q.pend  <= `RTSL_STAMP_RST;
      s_q.stamp <= `RTSL_STAMP_RST;
      s_q.armed <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stamp = s_q.stamp;

endmodule

/* File: hdl/rtsl_top.sv */
// What this block does
// - broadcast or matched configured write to trigger byte stamps every port's frame start.
// - variant mode: trigger stamps port 0 only and arms ports 1 to 3.
// - reading port 0 time gives last triggering frame's start time in every mode.
// - configured-address write triggers only when the node address matches.
// - position or other writes to trigger count in working counter but stamp only the processing unit, never the ports.
// - new stamps become readable only after the triggering frame ends.
// - ports 1, 2, 3 each hold the 32-bit start time of the triggering frame.
// - variant mode: armed port stamps its first next frame, then disarms.
// - processing unit holds 64-bit start time of the frame that wrote trigger.
// - any valid write command to the trigger byte triggers the processing-unit stamp.
// - with port 0 open, processing-unit stamp equals port 0 time zero-extended.
`include "rtsl_regs.svh"

module rtsl_top #(
  parameter bit ARM_MODE = 1'b0
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // local time base
  input  wire logic [63:0] local_time,
  // receive ports: one-cycle pulse at first preamble bit
  input  wire logic [3:0]  port_sof,
  input  wire logic        port0_open,
  // processing unit frame boundaries
  input  wire logic        pu_sof,
  input  wire logic        pu_eof,
  // network-side byte access, decoded by the frame parser
  input  wire logic        net_req,
  input  wire rtsl_pkg::rtsl_cmd_t net_cmd,
  input  wire logic        net_node_match,
  input  wire logic [15:0] net_addr,
  input  wire logic [7:0]  net_wdata,
  output logic [7:0]       net_rdata,
  output logic             net_ack,
  output logic             net_wkc_inc,
  // local host byte access
  input  wire logic        host_req,
  input  wire logic        host_we,
  input  wire logic [15:0] host_addr,
  output logic [7:0]       host_rdata,
  output logic             host_ack,
  output logic             host_err
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by both access sides, except the network-only address match

  function automatic logic in_window(input logic [15:0] a);
    in_window = (a >= `RTSL_WIN_BASE) && (a <= `RTSL_WIN_LAST);
  endfunction

  // broadcast always reaches us; the other kinds need their address match
  function automatic logic addressed_us(
    input rtsl_pkg::rtsl_cmd_t c,
    input logic                m
  );
    addressed_us = (c == rtsl_pkg::broadcast_write_cmd) || m;
  endfunction

  function automatic logic [7:0] read_byte(
    input logic [15:0]  a,
    input logic [127:0] ports,
    input logic [63:0]  pu
  );
    logic [3:0] idx;
    idx = 4'h0;
    idx = a[3:0];
    // the hole at 0x0910..0x0917 belongs to the system time block and reads zero here
    read_byte = `RTSL_BYTE_RST;
    if (a >= `RTSL_WIN_BASE && a <= `RTSL_PORT_WIN_LAST) begin
      read_byte = ports[{idx, 3'b000} +: 8];
    end else if (a >= `RTSL_PU_TIME_OFF && a <= `RTSL_PU_WIN_LAST) begin
      read_byte = pu[{a[2:0], 3'b000} +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // trigger qualification

  logic net_write;
  logic net_addressed;
  logic trig_hit;
  logic trig_port;
  logic trig_pu;
  logic commit_ports;
  logic net_take;
  logic host_take;

  assign net_write     = net_req && (net_cmd != rtsl_pkg::read_cmd);
  assign net_addressed = addressed_us(net_cmd, net_node_match);
  assign trig_hit      = net_write && net_addressed && (net_addr == `RTSL_TRIGGER_OFF);
  assign trig_port     = trig_hit &&
                         ((net_cmd == rtsl_pkg::broadcast_write_cmd) ||
                          (net_cmd == rtsl_pkg::configured_address_write_cmd));
  assign trig_pu       = trig_hit;
  // reads are answered whatever the node address; writes only when addressed
  assign net_take      = net_req && in_window(net_addr) &&
                         (net_addressed || (net_cmd == rtsl_pkg::read_cmd));
  assign host_take     = host_req && in_window(host_addr);

  rtsl_pkg::rtsl_top_st_t s_q;
  rtsl_pkg::rtsl_top_st_t s_d;

  // a trigger landing in the end-of-frame cycle still belongs to that frame
  assign commit_ports = pu_eof && (s_q.frame_trig || trig_port);

  ////////////////////////////////////////////////////////////////////////////
  // per-port capture

  logic [127:0] port_stamps;

  genvar g;
  generate
    for (g = 0; g < `RTSL_NPORTS; g++) begin : g_port
      // port 0 always commits at the end of a triggering frame; in the variant the others are armed
      // ports see only the low word of the time base
      localparam bit ARMED_PORT = ARM_MODE && (g != 0);
      rtsl_port_stamp u_stamp (
        .clock      (clock),
        .rst        (rst),
        .sof        (port_sof[g]),
        .local_time (local_time[31:0]),
        .commit     (commit_ports),
        .arm        (trig_port && ARMED_PORT),
        .arm_mode   (ARMED_PORT),
        .stamp      (port_stamps[g*32 +: 32])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // processing-unit capture and access answers

  always_comb begin
    s_d = s_q;
    s_d.net_ack     = 1'b0;
    s_d.net_wkc_inc = 1'b0;
    s_d.host_ack    = 1'b0;
    s_d.host_err    = 1'b0;

    // limitation: a frame that starts and ends in one cycle commits the older time
    if (pu_sof) begin
      if (port0_open) begin
        // port 0 pending stamp is latched the same edge; take the live time
        s_d.pu_pend = {32'h0000_0000, local_time[31:0]};
      end else begin
        s_d.pu_pend = local_time;
      end
    end

    // a trigger in the end-of-frame cycle commits at once, so the flags
    // can be cleared there without losing it
    if (pu_eof) begin
      if (s_q.pu_trig || trig_pu) begin
        s_d.pu_time = s_q.pu_pend;
      end
      s_d.frame_trig = 1'b0;
      s_d.pu_trig    = 1'b0;
    end else begin
      if (trig_port) begin
        s_d.frame_trig = 1'b1;
      end
      if (trig_pu) begin
        s_d.pu_trig = 1'b1;
      end
    end

    // network side: reads return committed stamps only, writes store nothing
    if (net_take) begin
      s_d.net_ack     = 1'b1;
      s_d.net_wkc_inc = 1'b1;
      if (!net_write) begin
        s_d.net_rdata = read_byte(net_addr, port_stamps, s_q.pu_time);
      end
    end

    // local host: read-only view, any write is refused; both sides read the same copies
    if (host_take) begin
      s_d.host_ack = 1'b1;
      if (host_we) begin
        s_d.host_err = 1'b1;
      end else begin
        s_d.host_rdata = read_byte(host_addr, port_stamps, s_q.pu_time);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q.frame_trig  <= 1'b0;
      s_q.pu_trig     <= 1'b0;
      s_q.pu_pend     <= `RTSL_PU_RST;
      s_q.pu_time     <= `RTSL_PU_RST;
      s_q.net_rdata   <= `RTSL_BYTE_RST;
      s_q.net_ack     <= 1'b0;
      s_q.net_wkc_inc <= 1'b0;
      s_q.host_rdata  <= `RTSL_BYTE_RST;
      s_q.host_ack    <= 1'b0;
      s_q.host_err    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // write data is never stored: the trigger byte has no storage of its own
  // only the access itself triggers, so the value written does not matter
  logic unused_wdata;
  assign unused_wdata = ^net_wdata;

  assign net_rdata   = s_q.net_rdata;
  assign net_ack     = s_q.net_ack;
  assign net_wkc_inc = s_q.net_wkc_inc;
  assign host_rdata  = s_q.host_rdata;
  assign host_ack    = s_q.host_ack;
  assign host_err    = s_q.host_err;

endmodule

/* File: shared/rtsl_pkg.sv */
package rtsl_pkg;

  // network-side command kinds, as decoded by the frame parser
  typedef enum logic [2:0] {
    broadcast_write_cmd          = 3'b000,
    configured_address_write_cmd = 3'b001,
    position_address_write_cmd   = 3'b010,
    other_write_cmd              = 3'b011,
    read_cmd                     = 3'b100
  } rtsl_cmd_t;

  typedef struct packed {
    logic [31:0] pend;
    logic [31:0] stamp;
    logic        armed;
  } rtsl_port_st_t;

  typedef struct packed {
    logic        frame_trig;
    logic        pu_trig;
    logic [63:0] pu_pend;
    logic [63:0] pu_time;
    logic [7:0]  net_rdata;
    logic        net_ack;
    logic        net_wkc_inc;
    logic [7:0]  host_rdata;
    logic        host_ack;
    logic        host_err;
  } rtsl_top_st_t;

endpackage

/* File: shared/rtsl_regs.svh */
`ifndef RTSL_REGS_SVH
`define RTSL_REGS_SVH

// byte offsets on the network-side / local-host address map
`define RTSL_PORT0_TIME_OFF 16'h0900
`define RTSL_PORT1_TIME_OFF 16'h0904
`define RTSL_PORT2_TIME_OFF 16'h0908
`define RTSL_PORT3_TIME_OFF 16'h090c
`define RTSL_PU_TIME_OFF    16'h0918
`define RTSL_TRIGGER_OFF    16'h0900

// window decoded by this block: 0x0900..0x091f
`define RTSL_WIN_BASE       16'h0900
`define RTSL_WIN_LAST       16'h091f
`define RTSL_PORT_WIN_LAST  16'h090f
`define RTSL_PU_WIN_LAST    16'h091f

// field layout
`define RTSL_PORT_W         32
`define RTSL_PU_W           64
`define RTSL_NPORTS         4

// capture values are undefined by nature; zero is used for a defined start
`define RTSL_STAMP_RST      32'h0000_0000
`define RTSL_PU_RST         64'h0000_0000_0000_0000
`define RTSL_BYTE_RST       8'h00

`endif

/* File: verif/rtsl_net_master.sv */
module rtsl_net_master (
  // clock
  input wire logic            clock,
  // frame events
  output logic [3:0]          port_sof,
  output logic                pu_sof,
  output logic                pu_eof,
  // byte access
  output logic                net_req,
  output rtsl_pkg::rtsl_cmd_t net_cmd,
  output logic                net_node_match,
  output logic [15:0]         net_addr,
  output logic [7:0]          net_wdata,
  input wire logic [7:0]      net_rdata,
  input wire logic            net_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {port_sof, pu_sof, pu_eof, net_req, net_node_match, net_addr, net_wdata} = '0;
    net_cmd = rtsl_pkg::read_cmd;
  end
  // a released address bus must not keep looking valid
  task automatic access(input rtsl_pkg::rtsl_cmd_t c, input logic m, input logic [15:0] a,
                        output logic [7:0] d, output logic ok);
    @(negedge clock);
    {net_req, net_cmd, net_node_match, net_addr, net_wdata} = {1'b1, c, m, a, 8'h5a};
    @(negedge clock);
    // the answer stands for one cycle only: take it before letting go
    {d, ok} = {net_rdata, net_ack};
    net_req = 1'b0;
    net_addr = ~a;
  endtask
  task automatic rd(input logic [15:0] a, input int n, output logic [63:0] v);
    logic [7:0] d;
    logic       ok;
    v = '0;
    for (int i = 0; i < n; i++) begin
      access(rtsl_pkg::read_cmd, 1'b0, a + 16'(i), d, ok);
      v[8*i +: 8] = ok ? d : 8'hxx;
    end
  endtask
  // trigger write inside the frame, then a peek before the frame ends
  task automatic frame(input rtsl_pkg::rtsl_cmd_t c, input logic m, output logic [63:0] peek);
    logic [7:0] d;
    logic       ok;
    @(negedge clock);
    port_sof = 4'hf;
    pu_sof = 1'b1;
    @(negedge clock);
    {port_sof, pu_sof} = '0;
    access(c, m, 16'h0900, d, ok);
    rd(16'h0900, 4, peek);
    pu_eof = 1'b1;
    @(negedge clock);
    pu_eof = 1'b0;
  endtask
endmodule

/* File: verif/rtsl_top_monitor.sv */
`include "rtsl_regs.svh"
module rtsl_top_monitor (
  // clock and reset
  input wire logic                clock,
  input wire logic                rst,
  // network side
  input wire logic                net_req,
  input wire rtsl_pkg::rtsl_cmd_t net_cmd,
  input wire logic                net_node_match,
  input wire logic [15:0]         net_addr,
  input wire logic                net_ack,
  input wire logic                net_wkc_inc,
  // local host
  input wire logic                host_req,
  input wire logic                host_we,
  input wire logic [15:0]         host_addr,
  input wire logic [7:0]          host_rdata,
  input wire logic                host_ack,
  input wire logic                host_err
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic n_ok = net_req && net_addr >= `RTSL_WIN_BASE && net_addr <= `RTSL_WIN_LAST &&
    (net_cmd == rtsl_pkg::broadcast_write_cmd || net_cmd == rtsl_pkg::read_cmd || net_node_match);
  wire logic h_ok = host_req && host_addr >= `RTSL_WIN_BASE && host_addr <= `RTSL_WIN_LAST;
  sequence net_take; n_ok; endsequence
  sequence host_wr; h_ok && host_we; endsequence
  net_ack_a: assert property (net_take |=> net_ack) else $error("net access not acked");
  net_refuse_a: assert property (!n_ok |=> !net_ack) else $error("stray net ack");
  wkc_pair_a: assert property (net_ack == net_wkc_inc) else $error("wkc and ack differ");
  host_ack_a: assert property (h_ok |=> host_ack) else $error("host access not acked");
  host_refuse_a: assert property (!h_ok |=> !host_ack) else $error("stray host ack");
  host_err_a: assert property (host_wr |=> host_err) else $error("host write not refused");
  host_rd_a: assert property (h_ok && !host_we |=> !host_err) else $error("read refused");
  rdata_hold_a: assert property (!(h_ok && !host_we) |=> $stable(host_rdata))
    else $error("host data moved");
endmodule

bind rtsl_top rtsl_top_monitor u_mon (.clock, .rst, .net_req, .net_cmd, .net_node_match,
  .net_addr, .net_ack, .net_wkc_inc, .host_req, .host_we, .host_addr, .host_rdata, .host_ack,
  .host_err);

/* File: verif/rtsl_top_tb.sv */
module rtsl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clock, rst, port0_open, pu_sof, pu_eof, net_req, net_node_match;
  logic                host_req, host_we, net_ack, net_wkc_inc, host_ack, host_err;
  logic [63:0]         local_time;
  logic [3:0]          port_sof;
  logic [15:0]         net_addr, host_addr;
  logic [7:0]          net_wdata, net_rdata, host_rdata;
  logic                arm_host_ack, arm_host_err;
  logic [7:0]          arm_host_rdata;
  rtsl_pkg::rtsl_cmd_t net_cmd;
  int                  miscompares = 0, samples_checked = 0, cycles = 0;
  rtsl_top DUT (.clock, .rst, .local_time, .port_sof, .port0_open, .pu_sof, .pu_eof, .net_req,
    .net_cmd, .net_node_match, .net_addr, .net_wdata, .net_rdata, .net_ack, .net_wkc_inc,
    .host_req, .host_we, .host_addr, .host_rdata, .host_ack, .host_err);
  // variant build on the same stimulus, read back through its host side
  rtsl_top #(.ARM_MODE(1'b1)) DUT_ARM (.clock, .rst, .local_time, .port_sof, .port0_open,
    .pu_sof, .pu_eof, .net_req, .net_cmd, .net_node_match, .net_addr, .net_wdata,
    .net_rdata(), .net_ack(), .net_wkc_inc(), .host_req, .host_we, .host_addr,
    .host_rdata(arm_host_rdata), .host_ack(arm_host_ack), .host_err(arm_host_err));
  rtsl_net_master master (.clock, .port_sof, .pu_sof, .pu_eof, .net_req, .net_cmd,
    .net_node_match, .net_addr, .net_wdata, .net_rdata, .net_ack);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic host_acc(input logic we, input logic [15:0] a, output logic [7:0] d,
                          output logic ack, output logic err);
    @(negedge clock);
    {host_req, host_we, host_addr} = {1'b1, we, a};
    @(negedge clock);
    {d, ack, err} = {host_rdata, host_ack, host_err};
    host_req = 1'b0;
  endtask
  // one 32-bit stamp of the variant build, byte by byte over its host side
  task automatic arm_rd(input logic [15:0] a, output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      {host_req, host_we, host_addr} = {1'b1, 1'b0, a + 16'(i)};
      @(negedge clock);
      v[8*i +: 8] = arm_host_ack ? arm_host_rdata : 8'hxx;
      host_req = 1'b0;
    end
  endtask
  // variant: port 0 commits as usual, ports 1 to 3 keep the first frame after each arm
  task automatic t_arm_variant();
    logic [31:0] av;
    arm_rd(16'h0900, av);
    chk(64'(av), 64'h0bad_cafe);
    for (int p = 1; p < 4; p++) begin
      arm_rd(16'h0900 + 16'(4 * p), av);
      chk(64'(av), 64'h2222_3333);
    end
  endtask
  task automatic check_stamps(input logic [31:0] p, input logic [63:0] pu);
    logic [63:0] v;
    for (int i = 0; i < 4; i++) begin
      master.rd(16'h0900 + 16'(4 * i), 4, v);
      chk(v, {32'h0, p});
    end
    master.rd(16'h0918, 8, v);
    chk(v, pu);
  endtask
  task automatic t_broadcast();
    logic [63:0] peek;
    logic [31:0] av;
    local_time = 64'h1234_5678_9abc_def0;
    master.frame(rtsl_pkg::broadcast_write_cmd, 1'b0, peek);
    chk(peek, 64'h0);
    check_stamps(32'h9abc_def0, 64'h1234_5678_9abc_def0);
    arm_rd(16'h0900, av);
    chk(64'(av), 64'h9abc_def0);
    arm_rd(16'h0904, av);
    chk(64'(av), 64'h0);
  endtask
  task automatic t_configured();
    logic [63:0] peek;
    port0_open = 1'b1;
    local_time = 64'hfeed_0000_0bad_cafe;
    master.frame(rtsl_pkg::configured_address_write_cmd, 1'b1, peek);
    chk(peek, 64'h9abc_def0);
    check_stamps(32'h0bad_cafe, 64'h0000_0000_0bad_cafe);
    local_time = 64'h0000_1111_2222_3333;
    master.frame(rtsl_pkg::configured_address_write_cmd, 1'b0, peek);
    check_stamps(32'h0bad_cafe, 64'h0000_0000_0bad_cafe);
    port0_open = 1'b0;
  endtask
  // position and other writes move only the processing-unit stamp
  task automatic t_other_writes();
    logic [63:0] peek;
    local_time = 64'h7777_6666_5555_4444;
    master.frame(rtsl_pkg::position_address_write_cmd, 1'b1, peek);
    check_stamps(32'h0bad_cafe, 64'h7777_6666_5555_4444);
    local_time = 64'h0a0b_0c0d_0e0f_1011;
    master.frame(rtsl_pkg::other_write_cmd, 1'b1, peek);
    check_stamps(32'h0bad_cafe, 64'h0a0b_0c0d_0e0f_1011);
  endtask
  task automatic t_host();
    logic [7:0] d;
    logic       ack, err;
    host_acc(1'b0, 16'h091f, d, ack, err);
    chk(64'({d, ack, err}), 64'({8'h0a, 2'b10}));
    host_acc(1'b1, 16'h0900, d, ack, err);
    chk(64'({ack, err}), 64'h3);
    host_acc(1'b0, 16'h0a00, d, ack, err);
    chk(64'(ack), 64'h0);
    check_stamps(32'h0bad_cafe, 64'h0a0b_0c0d_0e0f_1011);
  endtask
  initial begin
    {rst, port0_open, host_req, host_we, host_addr, local_time} = {1'b1, 83'h0};
    repeat (12) @(negedge clock);
    rst = 1'b0;
    t_broadcast();
    t_configured();
    t_other_writes();
    t_host();
    t_arm_variant();
    wrap_up();
  end
endmodule
